// file: include/dsm_pkg.sv
/*
 Register indices, reset values, field layouts and state types of the
 modulator, sweeper and auxiliary clock configuration block.
 Assumes a 32-bit bus where byte address = index * 4.
*/
package dsm_pkg;
    localparam logic [4:0] IDX_INT = 5'h0f;
    localparam logic [4:0] IDX_FRAC = 5'h10;
    localparam logic [4:0] IDX_SEED = 5'h11;
    localparam logic [4:0] IDX_MOD = 5'h12;
    localparam logic [4:0] IDX_STAT = 5'h13;
    localparam logic [4:0] IDX_CTRL = 5'h14;
    localparam logic [4:0] IDX_STEP = 5'h15;
    localparam logic [4:0] IDX_NUM = 5'h16;
    localparam logic [4:0] IDX_DWELL = 5'h17;
    localparam logic [4:0] IDX_AUXA = 5'h18;
    localparam logic [4:0] IDX_AUXB = 5'h19;
    localparam logic [15:0] RST_INT = 16'h00c8;
    localparam logic [23:0] RST_MOD = 24'h030e82;
    localparam logic [23:0] RST_RAMP = 24'h000800;
    localparam logic [23:0] RST_AUXA = 24'h0000a0;
    localparam logic [4:0] RST_AUXB = 5'h0f;
    localparam logic [9:0] RST_LFSR = 10'h001;
    localparam logic [2:0] DLY_MAX = 3'h7;

    typedef enum logic [1:0] {ORD_FIRST, ORD_SECOND, ORD_THIRD_FB, ORD_THIRD_FF} order_t;
    typedef enum logic [1:0] {S_IDLE, S_RAMP, S_HOLD, S_DWELL} ramp_st_t;

    typedef struct packed {
        logic [5:0] unused;
        logic signed [3:0] quant_min;
        logic signed [3:0] quant_max;
        order_t order;
        logic autoseed;
        logic xref_sine;
        logic [1:0] rsvd;
        logic integer_mode;
        logic invert_ref_phase;
        logic mod_clock_invert;
        logic ref_clk_select;
    } mod_cfg_t;

    typedef struct packed {
        logic single_dir;
        logic single_step;
        logic ext_trig_en;
        logic sweep_begin_downward;
        logic repeat_en;
        logic trigger;
        logic enable;
        logic clear;
    } sweep_ctrl_t;

    typedef struct packed {
        logic unused;
        logic [2:0] lodly;
        logic [7:0] fracstep;
        logic [1:0] mode;
        logic accum_en;
        logic lfsr_en;
        logic aux_sel;
        logic [2:0] divsel;
        logic [1:0] modesel;
        logic [1:0] insel;
    } aux_a_t;

    typedef struct packed {
        logic clk_ring;
        logic clk_inv;
        logic [2:0] hidly;
    } aux_b_t;
endpackage : dsm_pkg

// file: include/sweep_if.sv
/*
 Link between the register bank and the sweep engine.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface sweep_if;
    dsm_pkg::sweep_ctrl_t ctrl;
    logic trig;
    logic [23:0] step;
    logic [23:0] steps;
    logic [23:0] dwell;
    logic [23:0] base;
    logic [23:0] frac;
    logic busy;
    logic ovf;
    logic undf;
    modport engine(input ctrl, trig, step, steps, dwell, base, output frac, busy, ovf, undf);
    modport regs(output ctrl, trig, step, steps, dwell, base, input frac, busy, ovf, undf);
endinterface : sweep_if

// file: design/sweep_ramp.sv
/*
 Linear sweep engine: steps the fractional value up or down.
 Assumes hclk is the modulator update clock and trig is one cycle.
*/
`timescale 1ns/1ps
module sweep_ramp (
    input wire logic hclk,
    input wire logic hresetn,
    sweep_if.engine sw
);
    typedef struct packed {
        dsm_pkg::ramp_st_t st;
        logic [23:0] val;
        logic [23:0] start;
        logic [23:0] cnt;
        logic [23:0] dcnt;
        logic down;
        logic fresh;
        logic ovf;
        logic undf;
    } eng_t;
    eng_t s, n;
    logic [24:0] sum;
    logic stp;
    logic last;
    logic dn;

    always_comb begin
        n = s;
        stp = 1'b0;
        // Enable and start direction may arrive in one write, so the first step reads the bit live
        dn = s.fresh ? sw.ctrl.sweep_begin_downward : s.down; // see R13
        sum = dn ? {1'b0, s.val} - {1'b0, sw.step} : {1'b0, s.val} + {1'b0, sw.step}; // see R25
        last = (s.cnt + 24'h000001) >= sw.steps; // see R17
        case (s.st)
            dsm_pkg::S_IDLE: begin
                stp = sw.trig; // see R12
                n.start = s.val;
            end
            dsm_pkg::S_RAMP: stp = 1'b1;
            dsm_pkg::S_HOLD: stp = sw.trig; // see R15
            dsm_pkg::S_DWELL: begin
                // Auto trigger after the dwell
                if (s.dcnt + 24'h000001 >= sw.dwell) begin // see R18
                    n.st = dsm_pkg::S_RAMP;
                    n.dcnt = '0;
                    n.start = s.val;
                end else begin
                    n.dcnt = s.dcnt + 24'h000001;
                end
            end
            default: n.st = dsm_pkg::S_IDLE;
        endcase
        if (stp) begin
            n.val = sum[23:0];
            n.cnt = s.cnt + 24'h000001;
            n.down = dn;
            n.fresh = 1'b0;
            n.ovf = s.ovf | (sum[24] & ~dn); // see R25
            n.undf = s.undf | (sum[24] & dn);
            n.st = sw.ctrl.single_step ? dsm_pkg::S_HOLD : dsm_pkg::S_RAMP; // see R15
            if (last) begin
                n.cnt = '0;
                if (sw.ctrl.single_dir) begin
                    n.val = n.start; // see R16
                end else begin
                    n.down = ~dn;
                end
                n.st = sw.ctrl.repeat_en ? dsm_pkg::S_DWELL : dsm_pkg::S_IDLE; // see R12
            end
        end
        if (sw.ctrl.clear) begin
            n.ovf = 1'b0; // see R9
            n.undf = 1'b0;
        end
        if (!sw.ctrl.enable) begin
            n.st = dsm_pkg::S_IDLE; // see R10
            n.val = sw.base;
            n.cnt = '0;
            n.dcnt = '0;
            n.fresh = 1'b1;
            n.down = sw.ctrl.sweep_begin_downward; // see R13
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign sw.frac = s.val;
    assign sw.busy = s.st != dsm_pkg::S_IDLE;
    // Clear acts at once, not only at the next edge
    assign sw.ovf = s.ovf & ~sw.ctrl.clear; // see R9
    assign sw.undf = s.undf & ~sw.ctrl.clear;

    a_disable_idle: assert property (@(posedge hclk) disable iff (!hresetn) // see R10
        !sw.ctrl.enable |=> !sw.busy && sw.frac == $past(sw.base)) else $error("ramp not held in reset");
    a_clear_flags: assert property (@(posedge hclk) disable iff (!hresetn) // see R9
        sw.ctrl.clear |-> !sw.ovf && !sw.undf ##1 !s.ovf && !s.undf) else $error("flags not cleared");
    a_hold_stable: assert property (@(posedge hclk) disable iff (!hresetn) // see R15
        s.st == dsm_pkg::S_HOLD && !sw.trig && sw.ctrl.enable |=> $stable(s.val)) else $error("hold moved");
    a_dwell_stable: assert property (@(posedge hclk) disable iff (!hresetn) // see R18
        s.st == dsm_pkg::S_DWELL && sw.ctrl.enable |=> $stable(s.val)) else $error("dwell moved");
    a_ramp_stop: assert property (@(posedge hclk) disable iff (!hresetn) // see R12
        stp && last && !sw.ctrl.repeat_en && sw.ctrl.enable |=> !sw.busy) else $error("ramp kept going");
    a_step_add: assert property (@(posedge hclk) disable iff (!hresetn) // see R25
        s.st == dsm_pkg::S_RAMP && !last && sw.ctrl.enable && !s.down
        |=> s.val - $past(s.val) == $past(sw.step)) else $error("wrong step");
    a_first_dir: assert property (@(posedge hclk) disable iff (!hresetn) // see R13
        !sw.ctrl.enable |=> s.down == $past(sw.ctrl.sweep_begin_downward)) else $error("wrong start dir");
endmodule : sweep_ramp

// file: design/dsm_sweep_auxclk_config.sv
/*
 Modulator, sweeper and auxiliary clock configuration bank with an
 AHB-Lite slave, quantizer clamp, divider value, seed load and delay
 modulator. Assumes hclk is the modulator clock and that the
 quantizer input and trigger pin are synchronous to it.
*/
// Notes on behaviour
// R1 - Integer mode uses only the integer part; modulator output is bypassed.
// R2 - With autoseed set, each change of fraction loads the seed.
// R3 - Two-bit order field picks modulator structure; reset is third-order feedback.
// R4 - Quantizer output clamped between signed maximum and minimum fields.
// R5 - Bits select reference clocking, modulator clock invert and reference phase invert.
// R6 - Sine source is used when external reference path and bit both selected.
// R7 - Software keeps total sweep span within allowed multiple of reference.
// R8 - Software picks third-order feedforward whenever sweeping.
// R9 - Clear bit clears overflow and underflow flags at once.
// R10 - Ramp enable runs sweeper; cleared holds ramp logic in reset. Code keeps the overflow/underflow flags, and a trigger can still set them.
// R11 - Control write starts a ramp only when trigger bit was zero.
// R12 - Repeat retriggers ramps automatically; otherwise each ramp waits for trigger.
// R13 - Start-direction bit makes first ramp go down when one.
// R14 - Hardware trigger bit accepts ramp triggers from the third pin.
// R15 - Single-step mode takes one step per trigger then holds.
// R16 - Single-direction mode hops back to start at each ramp end.
// R17 - Step size and steps per ramp are 24 bits, reset 800h.
// R18 - Repeat mode dwells a 24-bit count at each ramp end.
// R19 - Auxiliary clock input select chooses one of four sources.
// R20 - Auxiliary mode field picks bypass, delay, ring; divider select resets 2h.
// R21 - Auxiliary select routes aux clock to modulator; optional inversion.
// R22 - Delay modulator with LFSR and accumulator toggling low/high delay.
// R23 - Divider is 16-bit integer plus 24-bit fraction; sweep alters fraction.
// R24 - 24-bit seed sets modulator start phase when loaded.
// R25 - Ramp adds or subtracts step each update and flags range exits.
`timescale 1ns/1ps
module dsm_sweep_auxclk_config (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic general_output_pin_three,
    input wire logic signed [3:0] quant_raw,
    output logic signed [3:0] quant_out,
    output logic [16:0] divider_n,
    output logic mod_bypass,
    output logic [23:0] frac_out,
    output logic [23:0] seed_value,
    output logic seed_load,
    output logic [1:0] mod_order,
    output logic mod_from_ref,
    output logic mod_clock_invert,
    output logic ref_phase_invert,
    output logic xref_sine_select,
    output logic [1:0] aux_src_sel,
    output logic [1:0] aux_mode,
    output logic [2:0] aux_div,
    output logic mod_uses_aux,
    output logic aux_clk_invert,
    output logic aux_ring_clocks_lfsr,
    output logic [2:0] delay_value,
    output logic ramp_busy,
    output logic ramp_ovf,
    output logic ramp_undf
);
    typedef struct packed {
        dsm_pkg::mod_cfg_t cfg;
        dsm_pkg::sweep_ctrl_t ctrl;
        logic [15:0] intg;
        logic [23:0] frac;
        logic [23:0] seed;
        logic [23:0] step;
        logic [23:0] steps;
        logic [23:0] dwell;
        dsm_pkg::aux_a_t auxa;
        dsm_pkg::aux_b_t auxb;
        logic wr;
        logic [4:0] widx;
        logic [31:0] rdata;
        logic pin_d;
        logic [23:0] frac_o;
        logic seed_load;
        logic [16:0] ndiv;
        logic signed [3:0] quant;
        logic [9:0] lfsr;
        logic [7:0] acc;
        logic sq;
        logic [2:0] dly;
    } top_t;

    localparam top_t TOP_RST = '{
        cfg: dsm_pkg::RST_MOD,
        intg: dsm_pkg::RST_INT,
        step: dsm_pkg::RST_RAMP,
        steps: dsm_pkg::RST_RAMP,
        dwell: dsm_pkg::RST_RAMP,
        auxa: dsm_pkg::RST_AUXA,
        auxb: dsm_pkg::RST_AUXB,
        lfsr: dsm_pkg::RST_LFSR,
        default: '0
    };

    top_t s, n;
    sweep_if sw();
    logic take;
    logic sw_trig;
    logic ext_trig;
    logic [23:0] frac_eff;
    logic [8:0] acc_sum;
    logic [4:0] ridx;

    function automatic logic signed [3:0] clamp(
        input logic signed [3:0] v,
        input logic signed [3:0] hi,
        input logic signed [3:0] lo
    );
        if (v > hi) begin
            clamp = hi;
        end else if (v < lo) begin
            clamp = lo;
        end else begin
            clamp = v;
        end
    endfunction : clamp

    sweep_ramp u_ramp (
        .hclk(hclk),
        .hresetn(hresetn),
        .sw(sw)
    );

    assign sw.ctrl = s.ctrl;
    assign sw.step = s.step; // see R17
    assign sw.steps = s.steps;
    assign sw.dwell = s.dwell;
    assign sw.base = s.frac; // see R23
    assign sw.trig = sw_trig | ext_trig;

    always_comb begin
        n = s;
        take = hsel & htrans[1] & hready;
        ridx = haddr[6:2];
        // Write data phase
        sw_trig = 1'b0;
        if (s.wr) begin
            case (s.widx)
                dsm_pkg::IDX_INT: n.intg = hwdata[15:0]; // see R23
                dsm_pkg::IDX_FRAC: n.frac = hwdata[23:0];
                dsm_pkg::IDX_SEED: n.seed = hwdata[23:0]; // see R24
                dsm_pkg::IDX_MOD: n.cfg = hwdata[23:0];
                dsm_pkg::IDX_CTRL: begin
                    n.ctrl = hwdata[7:0];
                    // A held trigger bit blocks retriggering
                    sw_trig = hwdata[2] & ~s.ctrl.trigger; // see R11
                end
                dsm_pkg::IDX_STEP: n.step = hwdata[23:0];
                dsm_pkg::IDX_NUM: n.steps = hwdata[23:0];
                dsm_pkg::IDX_DWELL: n.dwell = hwdata[23:0];
                dsm_pkg::IDX_AUXA: n.auxa = hwdata[23:0];
                dsm_pkg::IDX_AUXB: n.auxb = hwdata[4:0];
                default: n.intg = s.intg;
            endcase
        end
        // Address phase; unmapped or misaligned writes are dropped
        n.wr = take & hwrite & (haddr[31:7] == 25'h0) & (haddr[1:0] == 2'h0);
        n.widx = ridx;
        // Read mux sees this cycle's write, so write-then-read is coherent
        if (take && !hwrite) begin
            case (ridx)
                dsm_pkg::IDX_INT: n.rdata = {16'h0000, n.intg};
                dsm_pkg::IDX_FRAC: n.rdata = {8'h00, n.frac};
                dsm_pkg::IDX_SEED: n.rdata = {8'h00, n.seed};
                dsm_pkg::IDX_MOD: n.rdata = {8'h00, n.cfg};
                dsm_pkg::IDX_STAT: n.rdata = {26'h0, s.dly, sw.undf, sw.ovf, sw.busy};
                dsm_pkg::IDX_CTRL: n.rdata = {24'h000000, n.ctrl};
                dsm_pkg::IDX_STEP: n.rdata = {8'h00, n.step};
                dsm_pkg::IDX_NUM: n.rdata = {8'h00, n.steps};
                dsm_pkg::IDX_DWELL: n.rdata = {8'h00, n.dwell};
                dsm_pkg::IDX_AUXA: n.rdata = {8'h00, n.auxa};
                dsm_pkg::IDX_AUXB: n.rdata = {27'h0, n.auxb};
                default: n.rdata = 32'h00000000;
            endcase
            if (haddr[31:7] != 25'h0 || haddr[1:0] != 2'h0) begin
                n.rdata = 32'h00000000;
            end
        end
        // Pin edge; pin is already synchronous
        n.pin_d = general_output_pin_three;
        ext_trig = s.ctrl.ext_trig_en & general_output_pin_three & ~s.pin_d; // see R14
        // Divider value and clamp
        n.quant = clamp(quant_raw, s.cfg.quant_max, s.cfg.quant_min); // see R4
        if (s.cfg.integer_mode) begin
            n.ndiv = {1'b0, s.intg}; // see R1
        end else begin
            n.ndiv = {1'b0, s.intg} + {{13{n.quant[3]}}, n.quant};
        end
        frac_eff = s.ctrl.enable ? sw.frac : s.frac; // see R23
        n.frac_o = frac_eff;
        n.seed_load = s.cfg.autoseed & (frac_eff != s.frac_o); // see R2
        // Delay modulator
        if (s.auxa.lfsr_en) begin
            n.lfsr = {s.lfsr[8:0], s.lfsr[9] ^ s.lfsr[6]}; // see R22
        end
        acc_sum = {1'b0, s.acc} + {1'b0, s.auxa.fracstep};
        if (s.auxa.accum_en) begin
            n.acc = acc_sum[7:0];
            n.sq = s.sq ^ acc_sum[8]; // see R22
        end
        case (s.auxa.mode)
            2'h0: n.dly = s.auxa.lodly;
            2'h1: n.dly = s.sq ? s.auxb.hidly : s.auxa.lodly;
            // Low amplitude dithers one step, saturating at the top
            2'h2: n.dly = (s.lfsr[0] && s.auxa.lodly != dsm_pkg::DLY_MAX) ? s.auxa.lodly + 3'h1 : s.auxa.lodly;
            2'h3: n.dly = s.lfsr[0] ? s.auxb.hidly : s.auxa.lodly;
            default: n.dly = s.auxa.lodly;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= TOP_RST;
        end else begin
            s <= n;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;
    assign quant_out = s.quant;
    assign divider_n = s.ndiv;
    assign mod_bypass = s.cfg.integer_mode; // see R1
    assign frac_out = s.frac_o;
    assign seed_value = s.seed; // see R24
    assign seed_load = s.seed_load;
    assign mod_order = s.cfg.order; // see R3
    assign mod_from_ref = s.cfg.ref_clk_select; // see R5
    assign mod_clock_invert = s.cfg.mod_clock_invert;
    assign ref_phase_invert = s.cfg.invert_ref_phase;
    assign xref_sine_select = s.cfg.xref_sine & (s.auxa.insel == 2'h1); // see R6
    assign aux_src_sel = s.auxa.insel; // see R19
    assign aux_mode = s.auxa.modesel; // see R20
    assign aux_div = s.auxa.divsel;
    assign mod_uses_aux = s.auxa.aux_sel; // see R21
    assign aux_clk_invert = s.auxb.clk_inv;
    assign aux_ring_clocks_lfsr = s.auxb.clk_ring;
    assign delay_value = s.dly;
    assign ramp_busy = sw.busy;
    assign ramp_ovf = sw.ovf;
    assign ramp_undf = sw.undf;

    a_integer_bypass: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
        s.cfg.integer_mode |=> divider_n == {1'b0, $past(s.intg)}) else $error("integer mode not bypassed");
    a_autoseed_load: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
        s.cfg.autoseed && frac_eff != s.frac_o |=> seed_load && frac_out == $past(frac_eff))
        else $error("seed not loaded");
    a_quant_clamp: assert property (@(posedge hclk) disable iff (!hresetn) // see R4
        s.cfg.quant_max >= s.cfg.quant_min
        |=> quant_out <= $past(s.cfg.quant_max) && quant_out >= $past(s.cfg.quant_min))
        else $error("quantizer not clamped");
    a_retrigger_block: assert property (@(posedge hclk) disable iff (!hresetn) // see R11
        s.ctrl.trigger && !s.ctrl.ext_trig_en |-> !sw.trig) else $error("trigger while bit held");
    a_ext_trigger: assert property (@(posedge hclk) disable iff (!hresetn) // see R14
        ext_trig && s.ctrl.enable && !ramp_busy && s.steps > 24'h000001 && n.ctrl.enable
        |=> ramp_busy) else $error("pin trigger ignored");
    a_sweep_frac: assert property (@(posedge hclk) disable iff (!hresetn) // see R23
        s.ctrl.enable |=> frac_out == $past(sw.frac)) else $error("sweep value not output");
endmodule : dsm_sweep_auxclk_config

// file: verification/tb_top.sv
/*
 Self-checking bench for the modulator, sweep and aux clock register bank.
 Assumes a zero-wait AHB-Lite slave, with byte address = index * 4.
*/
`timescale 1ns/1ps
module tb_top;
    typedef struct {string nm; logic [31:0] v;} note_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic pin = 1'b0;
    logic signed [3:0] quant_raw = 4'sh0;
    logic hreadyout, hresp, mod_bypass, ramp_busy, ramp_ovf, mod_clock_invert, mod_uses_aux;
    logic [31:0] hrdata;
    logic signed [3:0] quant_out;
    logic [16:0] divider_n;
    logic [23:0] frac_out;
    logic [1:0] mod_order;
    logic [2:0] aux_div;
    logic seed_load, aux_clk_invert;
    logic [23:0] seed_value;
    logic [2:0] delay_value;
    int loads = 0;
    note_t notes[$];
    logic [31:0] seens[$];
    int err_total = 0;
    int checked = 0;
    always #2 hclk = ~hclk;
    dsm_sweep_auxclk_config uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .general_output_pin_three(pin),
        .quant_raw(quant_raw), .quant_out(quant_out), .divider_n(divider_n), .mod_bypass(mod_bypass),
        .frac_out(frac_out), .seed_value(seed_value), .seed_load(seed_load), .mod_order(mod_order), .mod_from_ref(),
        .mod_clock_invert(mod_clock_invert), .ref_phase_invert(), .xref_sine_select(),
        .aux_src_sel(), .aux_mode(), .aux_div(aux_div), .mod_uses_aux(mod_uses_aux),
        .aux_clk_invert(aux_clk_invert), .aux_ring_clocks_lfsr(), .delay_value(delay_value), .ramp_busy(ramp_busy),
        .ramp_ovf(ramp_ovf), .ramp_undf());
    // Counts cycles with the autoseed pulse high; one fraction change gives one cycle, a running ramp gives one per step
    always @(posedge hclk) begin
        if (seed_load === 1'b1) begin
            loads <= loads + 1;
        end
    end
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : cmp
    task automatic note(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        notes.push_back('{nm, exp});
        seens.push_back(seen);
    endtask : note
    // Second process: compares oldest note against oldest observation
    initial begin : watch
        note_t n;
        logic [31:0] s;
        forever begin
            wait (seens.size() != 0);
            n = notes.pop_front();
            s = seens.pop_front();
            cmp(n.nm, s, n.v);
        end
    end
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_total++;
            end_of_test();
        end
    endtask : wait_ready
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        // Register outputs change at the edge that ends the data phase
        #1;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask : rd
    // Waits for the engine to go idle; single step parks in hold instead
    task automatic run(input logic [7:0] c, input logic use_pin, input logic rearm);
        int n;
        if (rearm) begin
            wr(32'h50, 32'h0);
            wr(32'h50, {24'h0, c & 8'hfb});
        end
        if (use_pin) begin
            @(posedge hclk);
            pin <= 1'b1;
            @(posedge hclk);
            pin <= 1'b0;
        end else begin
            wr(32'h50, {24'h0, c});
        end
        repeat (2) @(posedge hclk);
        n = 0;
        while (!c[6] && ramp_busy !== 1'b0 && n < 64) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 64) begin
            err_total++;
            end_of_test();
        end
        repeat (3) @(posedge hclk);
    endtask : run
    logic [31:0] q;
    logic [31:0] d;
    logic [31:0] addrs[9] = '{32'h3c, 32'h40, 32'h48, 32'h54, 32'h58, 32'h5c, 32'h60, 32'h64, 32'h68};
    logic [31:0] rstv[9] = '{32'hc8, 32'h0, 32'h030e82, 32'h800, 32'h800, 32'h800, 32'ha0, 32'h0f, 32'h0};
    int e;
    int l0;
    initial begin
        void'($urandom(96405));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        note("order", {30'h0, mod_order}, 32'h2);
        note("clk_inv", {31'h0, mod_clock_invert}, 32'h1);
        note("aux_sel", {31'h0, mod_uses_aux}, 32'h1);
        note("aux_div", {29'h0, aux_div}, 32'h2);
        note("aux_inv", {31'h0, aux_clk_invert}, 32'h1);
        for (int i = 0; i < 9; i++) begin
            rd(addrs[i], q);
            note("reset", q, rstv[i]);
        end
        rd(32'h80, q);
        note("outside", q, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            d = $urandom() & 32'hffffff;
            wr(32'h5c, d);
            rd(32'h5c, q);
            note("dwell", q, d);
            wr(32'h48, {8'h0, 14'h00c3, i[1:0], 8'h80 | {4'h0, i[0], 3'h0}});
            note("order", {30'h0, mod_order}, i);
            note("bypass", {31'h0, mod_bypass}, {31'h0, i[0]});
            if (i[0]) begin
                note("int_div", {15'h0, divider_n}, 32'hc8);
            end
        end
        wr(32'h48, 32'h030f82);
        d = $urandom() & 32'hffffff;
        wr(32'h44, d);
        rd(32'h44, q);
        note("seed_rd", q, d);
        note("seed", {8'h0, seed_value}, d);
        d = $urandom() & 32'h7;
        wr(32'h60, {9'h0, d[2:0], 20'h000a0});
        repeat (2) @(posedge hclk);
        note("delay", {29'h0, delay_value}, {29'h0, d[2:0]});
        $display("test config fields done");
        for (int v = -8; v < 8; v++) begin
            @(posedge hclk);
            quant_raw <= 4'(v);
            repeat (2) @(posedge hclk);
            e = v > 3 ? 3 : (v < -4 ? -4 : v);
            note("clamp", {28'h0, quant_out}, {28'h0, 4'(e)});
        end
        $display("test clamp done");
        wr(32'h40, 32'h100);
        wr(32'h54, 32'h10);
        wr(32'h58, 32'h2);
        run(8'h06, 1'b0, 1'b1);
        note("up", {8'h0, frac_out}, 32'h120);
        run(8'h06, 1'b0, 1'b0);
        note("held_busy", {31'h0, ramp_busy}, 32'h0);
        note("held", {8'h0, frac_out}, 32'h120);
        wr(32'h50, 32'h02);
        run(8'h06, 1'b0, 1'b0);
        note("back", {8'h0, frac_out}, 32'h100);
        run(8'h16, 1'b0, 1'b1);
        note("down", {8'h0, frac_out}, 32'he0);
        run(8'h46, 1'b0, 1'b1);
        note("one_step", {8'h0, frac_out}, 32'h110);
        run(8'h22, 1'b1, 1'b1);
        note("pin", {8'h0, frac_out}, 32'h120);
        run(8'h86, 1'b0, 1'b1);
        note("hop", {8'h0, frac_out}, 32'h100);
        wr(32'h40, 32'hfffff0);
        run(8'h06, 1'b0, 1'b1);
        note("ovf", {31'h0, ramp_ovf}, 32'h1);
        wr(32'h50, 32'h07);
        note("cleared", {31'h0, ramp_ovf}, 32'h0);
        wr(32'h50, 32'h00);
        repeat (3) @(posedge hclk);
        note("disabled", {8'h0, frac_out}, 32'hfffff0);
        l0 = loads;
        wr(32'h40, 32'h000123);
        repeat (3) @(posedge hclk);
        note("seed_load", loads - l0, 32'h1);
        $display("test sweep done");
        wait (seens.size() == 0);
        #1;
        end_of_test();
    end
endmodule : tb_top
